// ===== include/cffc_pkg.sv
// Package of constants and carrier types for the CAN filter and queue block.
package cffc_pkg;
    // Register map, byte addresses on the APB.
    localparam logic [11:0] CFFC_FILTER_BASE = 12'h000;
    localparam int CFFC_FILTER_WORDS = 8;
    localparam logic [11:0] CFFC_MAIN_ADDR = 12'h020;
    localparam logic [11:0] CFFC_MASK_BASE = 12'h040;
    localparam int CFFC_MASK_WORDS = 4;
    localparam logic [11:0] CFFC_QUEUE_BASE = 12'h080;
    localparam int CFFC_QUEUES = 32;
    localparam logic [11:0] CFFC_FID_BASE = 12'h100;
    localparam int CFFC_FILTERS = 32;
    // Filter lane layout, four lanes per word.
    localparam int CFFC_LANE_W = 8;
    localparam int CFFC_LANES = 4;
    localparam int CFFC_LANE_EN = 7;
    localparam int CFFC_LANE_MSEL_LO = 5;
    localparam int CFFC_LANE_DEST_LO = 0;
    localparam logic [7:0] CFFC_LANE_RESET = 8'h00;
    // Queue control register bits.
    localparam int CFFC_QC_DIR = 7;
    localparam int CFFC_QC_ABORT = 6;
    localparam int CFFC_QC_ARB = 5;
    localparam int CFFC_QC_ERR = 4;
    localparam int CFFC_QC_REQ = 3;
    localparam int CFFC_QC_RTR = 2;
    localparam int CFFC_QC_PRI_LO = 0;
    // Main control register: operating mode field.
    localparam int CFFC_OPMODE_LO = 21;
    localparam logic [2:0] CFFC_OPMODE_CONFIG = 3'h4;
    localparam logic [2:0] CFFC_OPMODE_RESET = 3'h4;
    localparam int CFFC_ID_W = 29;
    localparam logic [1:0] CFFC_BUF_DEPTH = 2'h2;

    typedef struct packed {
        logic [CFFC_ID_W-1:0] id;
    } cffc_rx_frame_t;

    typedef struct packed {
        logic [CFFC_ID_W-1:0] id;
        logic [4:0] dest;
        logic [4:0] filter;
    } cffc_routed_t;

    typedef struct packed {
        logic valid;
        logic [4:0] index;
        logic completed;
        logic aborted;
        logic arb_lost;
        logic bus_error;
        logic queue_empty;
    } cffc_tx_event_t;

    typedef struct packed {
        logic valid;
        logic [4:0] index;
        logic [1:0] priority_level;
    } cffc_offer_t;
endpackage : cffc_pkg

// ===== rtl/cffc_top.sv
// CAN acceptance filter routing and per-queue transmit control.
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module cffc_top
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Received frames from the bit engine.
    input wire logic rx_valid,
    input wire cffc_pkg::cffc_rx_frame_t rx_frame,
    output logic rx_ready,
    // Routed frames toward queue storage.
    output logic route_valid,
    output cffc_pkg::cffc_routed_t route_data,
    input wire logic route_ready,
    // Transmit engine events and queue resets.
    input wire cffc_pkg::cffc_tx_event_t tx_event,
    input wire logic remote_valid,
    input wire logic [4:0] remote_index,
    input wire logic [31:0] queue_reset,
    // Transmit offer and mode.
    output cffc_pkg::cffc_offer_t tx_offer,
    output logic [2:0] operating_mode
);
    import cffc_pkg::*;

    function automatic logic in_range(input logic [11:0] addr,
                                      input logic [11:0] base,
                                      input int words);
        in_range = (addr >= base) && ({20'h0, addr} < {20'h0, base}
                   + 32'(words * 4));
    endfunction : in_range

    function automatic logic [4:0] word_index(input logic [11:0] addr,
                                              input logic [11:0] base);
        logic [11:0] diff;
        diff = addr - base;
        word_index = diff[6:2];
    endfunction : word_index

    logic [7:0] flt [CFFC_FILTERS];
    logic [CFFC_ID_W-1:0] fid [CFFC_FILTERS];
    logic [CFFC_ID_W-1:0] mask [CFFC_MASK_WORDS];
    logic [31:0] q_dir, q_abort, q_arb, q_err, q_req, q_rtr;
    logic [1:0] q_pri [CFFC_QUEUES];
    logic [1:0] buf_cnt;
    cffc_routed_t buf1;

    // Bus decode. The slave inserts one wait state so read data is a flop.
    wire acc = psel & penable;
    wire wr_fire = acc & pready & pwrite;
    wire rd_fire = acc & pready & ~pwrite;
    wire aligned = (paddr[1:0] == 2'h0);
    wire hit_flt = aligned & in_range(paddr, CFFC_FILTER_BASE,
                                      CFFC_FILTER_WORDS);
    wire hit_main = aligned & (paddr == CFFC_MAIN_ADDR);
    wire hit_mask = aligned & in_range(paddr, CFFC_MASK_BASE,
                                       CFFC_MASK_WORDS);
    wire hit_q = aligned & in_range(paddr, CFFC_QUEUE_BASE, CFFC_QUEUES);
    wire hit_fid = aligned & in_range(paddr, CFFC_FID_BASE, CFFC_FILTERS);
    wire mapped = hit_flt | hit_main | hit_mask | hit_q | hit_fid;
    wire [4:0] flt_w = word_index(paddr, CFFC_FILTER_BASE);
    wire [4:0] mask_w = word_index(paddr, CFFC_MASK_BASE);
    wire [4:0] q_w = word_index(paddr, CFFC_QUEUE_BASE);
    wire [4:0] fid_w = word_index(paddr, CFFC_FID_BASE);
    wire [2:0] flt_word = flt_w[2:0];
    wire cfg_mode = (operating_mode == CFFC_OPMODE_CONFIG);

    wire [31:0] flt_rd = {flt[{flt_word, 2'h3}], flt[{flt_word, 2'h2}],
                          flt[{flt_word, 2'h1}], flt[{flt_word, 2'h0}]};
    wire [31:0] q_rd = {24'h0, q_dir[q_w], q_abort[q_w], q_arb[q_w],
                        q_err[q_w], q_req[q_w], q_rtr[q_w], q_pri[q_w]};
    wire [31:0] main_rd = {8'h0, operating_mode, 21'h0};
    wire [31:0] rd_word = hit_flt ? flt_rd :
                          hit_main ? main_rd :
                          hit_mask ? {3'h0, mask[mask_w[1:0]]} :
                          hit_q ? q_rd :
                          hit_fid ? {3'h0, fid[fid_w]} : 32'h0;

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end
        else
        begin
            pready <= acc & ~pready;
            pslverr <= acc & ~pready & ~mapped;
            if (acc & ~pready)
                prdata <= pwrite ? 32'h0 : rd_word;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
            operating_mode <= CFFC_OPMODE_RESET;
        else if (wr_fire & hit_main & pstrb[2])
            operating_mode <= pwdata[CFFC_OPMODE_LO +: 3];
    end

    // Filter lanes: enable always writable, the rest only while disabled.
    always_ff @(posedge core_clk)
    begin
        for (int f = 0; f < CFFC_FILTERS; f++)
        begin
            if (reset)
                flt[f] <= CFFC_LANE_RESET;
            else if (wr_fire & hit_flt & (flt_word == 3'(f / CFFC_LANES))
                     & pstrb[f % CFFC_LANES])
            begin
                flt[f][CFFC_LANE_EN] <= pwdata[(f % CFFC_LANES) *
                    CFFC_LANE_W + CFFC_LANE_EN];
                if (!flt[f][CFFC_LANE_EN])
                    flt[f][CFFC_LANE_EN-1:0] <= pwdata[(f % CFFC_LANES) *
                        CFFC_LANE_W +: CFFC_LANE_EN];
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        for (int f = 0; f < CFFC_FILTERS; f++)
        begin
            if (reset)
                fid[f] <= '0;
            else if (wr_fire & hit_fid & (fid_w == 5'(f)))
                fid[f] <= pwdata[CFFC_ID_W-1:0];
        end
        for (int m = 0; m < CFFC_MASK_WORDS; m++)
        begin
            if (reset)
                mask[m] <= '0;
            else if (wr_fire & hit_mask & (mask_w[1:0] == 2'(m)))
                mask[m] <= pwdata[CFFC_ID_W-1:0];
        end
    end

    // Queue control. Hardware sets win over the read clear in one cycle.
    always_ff @(posedge core_clk)
    begin
        for (int n = 0; n < CFFC_QUEUES; n++)
        begin
            if (reset)
            begin
                q_dir[n] <= 1'b0;
                q_abort[n] <= 1'b0;
                q_arb[n] <= 1'b0;
                q_err[n] <= 1'b0;
                q_req[n] <= 1'b0;
                q_rtr[n] <= 1'b0;
                q_pri[n] <= 2'h0;
            end
            else if (queue_reset[n])
            begin
                q_abort[n] <= 1'b0;
                q_arb[n] <= 1'b0;
                q_err[n] <= 1'b0;
                q_req[n] <= 1'b0;
            end
            else
            begin
                if (wr_fire & hit_q & (q_w == 5'(n)) & pstrb[0])
                begin
                    q_pri[n] <= pwdata[CFFC_QC_PRI_LO +: 2];
                    q_rtr[n] <= pwdata[CFFC_QC_RTR];
                    if (cfg_mode)
                        q_dir[n] <= pwdata[CFFC_QC_DIR];
                end
                if (tx_event.valid & (tx_event.index == 5'(n))
                    & (tx_event.completed | tx_event.aborted))
                    q_abort[n] <= tx_event.aborted;
                if (tx_event.valid & (tx_event.index == 5'(n))
                    & tx_event.arb_lost)
                    q_arb[n] <= 1'b1;
                else if (rd_fire & hit_q & (q_w == 5'(n)))
                    q_arb[n] <= 1'b0;
                if (tx_event.valid & (tx_event.index == 5'(n))
                    & tx_event.bus_error)
                    q_err[n] <= 1'b1;
                else if (rd_fire & hit_q & (q_w == 5'(n)))
                    q_err[n] <= 1'b0;
                if ((wr_fire & hit_q & (q_w == 5'(n)) & pstrb[0]
                     & pwdata[CFFC_QC_REQ] & q_dir[n])
                    | (remote_valid & (remote_index == 5'(n)) & q_rtr[n]))
                    q_req[n] <= 1'b1;
                else if (tx_event.valid & (tx_event.index == 5'(n))
                         & tx_event.completed & tx_event.queue_empty)
                    q_req[n] <= 1'b0;
            end
        end
    end

    // Pick the highest priority; ties go to the lowest queue index.
    cffc_offer_t pick;
    always_comb
    begin
        pick = '0;
        for (int n = 0; n < CFFC_QUEUES; n++)
        begin
            if (q_dir[n] & q_req[n]
                & (!pick.valid | (q_pri[n] > pick.priority_level)))
            begin
                pick.valid = 1'b1;
                pick.index = 5'(n);
                pick.priority_level = q_pri[n];
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
            tx_offer <= '0;
        else
            tx_offer <= pick;
    end

    // Acceptance: the lowest-numbered enabled matching filter wins.
    logic hit_any;
    logic [4:0] win;
    always_comb
    begin
        hit_any = 1'b0;
        win = 5'h0;
        for (int f = CFFC_FILTERS - 1; f >= 0; f--)
        begin
            if (flt[f][CFFC_LANE_EN] & (((rx_frame.id ^ fid[f])
                & mask[flt[f][CFFC_LANE_MSEL_LO +: 2]]) == '0))
            begin
                hit_any = 1'b1;
                win = 5'(f);
            end
        end
    end

    cffc_routed_t new_entry;
    assign new_entry.id = rx_frame.id;
    assign new_entry.dest = flt[win][CFFC_LANE_DEST_LO +: 5];
    assign new_entry.filter = win;

    // Two-entry buffer; entry zero drives the output directly.
    wire push = rx_valid & rx_ready & hit_any;
    wire pop = route_valid & route_ready;
    wire [1:0] rem = pop ? buf_cnt - 2'h1 : buf_cnt;
    wire [1:0] next_cnt = rem + {1'b0, push};

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            buf_cnt <= 2'h0;
            route_valid <= 1'b0;
            rx_ready <= 1'b0;
            route_data <= '0;
            buf1 <= '0;
        end
        else
        begin
            buf_cnt <= next_cnt;
            route_valid <= (next_cnt != 2'h0);
            rx_ready <= (next_cnt != CFFC_BUF_DEPTH);
            if (pop & (buf_cnt == CFFC_BUF_DEPTH))
                route_data <= buf1;
            if (push & (rem == 2'h0))
                route_data <= new_entry;
            else if (push)
                buf1 <= new_entry;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    wire ev0 = tx_event.valid & (tx_event.index == 5'h0);
    wire wr_q0 = wr_fire & hit_q & (q_w == 5'h0) & pstrb[0];

    property p_lane_locked;
        wr_fire & hit_flt & (flt_word == 3'h2) & pstrb[0]
            & flt[8][CFFC_LANE_EN]
        |=> flt[8][CFFC_LANE_EN-1:0] == $past(flt[8][CFFC_LANE_EN-1:0]);
    endproperty
    a_lane_locked: assert property (p_lane_locked)
        else $error("Locked filter fields changed while enabled.");

    property p_route_enabled;
        push |-> flt[win][CFFC_LANE_EN] & (buf_cnt != CFFC_BUF_DEPTH);
    endproperty
    a_route_enabled: assert property (p_route_enabled)
        else $error("Frame routed through a disabled filter.");

    property p_abort_value;
        ev0 & (tx_event.completed | tx_event.aborted) & ~queue_reset[0]
        |=> q_abort[0] == $past(tx_event.aborted);
    endproperty
    a_abort_value: assert property (p_abort_value)
        else $error("Aborted flag does not follow message outcome.");

    property p_abort_stable;
        ~(ev0 & (tx_event.completed | tx_event.aborted)) & ~queue_reset[0]
        |=> $stable(q_abort[0]);
    endproperty
    a_abort_stable: assert property (p_abort_stable)
        else $error("Aborted flag changed without a cause.");

    property p_arb_set;
        ev0 & tx_event.arb_lost & ~queue_reset[0] |=> q_arb[0] ##1 1'b1;
    endproperty
    a_arb_set: assert property (p_arb_set)
        else $error("Arbitration-lost flag not set.");

    property p_err_set;
        ev0 & tx_event.bus_error & ~queue_reset[0] |=> q_err[0];
    endproperty
    a_err_set: assert property (p_err_set)
        else $error("Send-error flag not set.");

    property p_read_clear;
        rd_fire & hit_q & (q_w == 5'h0) & ~(ev0 & tx_event.arb_lost)
        |=> ~q_arb[0];
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("Arbitration-lost flag survived a read.");

    property p_rx_queue_req;
        wr_q0 & ~q_dir[0] & ~(remote_valid & (remote_index == 5'h0))
            & ~ev0 & ~queue_reset[0]
        |=> $stable(q_req[0]);
    endproperty
    a_rx_queue_req: assert property (p_rx_queue_req)
        else $error("Send request changed on a receive queue.");

    property p_req_done;
        ev0 & tx_event.completed & tx_event.queue_empty & ~wr_q0
            & ~remote_valid
        |=> ~q_req[0];
    endproperty
    a_req_done: assert property (p_req_done)
        else $error("Send request not cleared after last message.");

    property p_auto_reply;
        remote_valid & (remote_index == 5'h0) & q_rtr[0] & ~queue_reset[0]
        |=> q_req[0] && (pick.valid || !q_dir[0]);
    endproperty
    a_auto_reply: assert property (p_auto_reply)
        else $error("Remote request did not raise send request.");

    property p_cfg_only;
        wr_q0 & ~cfg_mode & ~queue_reset[0] |=> $stable(q_dir[0]);
    endproperty
    a_cfg_only: assert property (p_cfg_only)
        else $error("Direction changed outside configuration mode.");

    c_route: cover property (push ##[1:4] pop);
    c_full: cover property (rx_valid & ~rx_ready);
    c_offer: cover property (wr_q0 ##[1:8] tx_offer.valid);
endmodule : cffc_top

// ===== testbench/cffc_far_end.sv
// Queue storage side model: takes routed frames and can stall on command.
`timescale 1ns/1ps
module cffc_far_end
    import cffc_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset,
    // Stall command from the bench.
    input wire logic stall,
    // Routed frame stream.
    input wire logic route_valid,
    input wire cffc_pkg::cffc_routed_t route_data,
    output logic route_ready
);
    cffc_routed_t got[$];

    // Ready follows the stall directly, so a full buffer is seen at once.
    assign route_ready = !stall;

    always @(posedge core_clk)
        if (!reset && route_valid && route_ready)
            got.push_back(route_data);
endmodule : cffc_far_end

// ===== testbench/tb.sv
// Self-checking bench for the CAN filter and queue control block.
`timescale 1ns/1ps
module tb;
    import cffc_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rx_valid = 1'b0;
    cffc_rx_frame_t rx_frame = '0;
    logic rx_ready;
    logic route_valid;
    cffc_routed_t route_data;
    logic route_ready;
    cffc_tx_event_t tx_event = '0;
    logic remote_valid = 1'b0;
    logic [4:0] remote_index = 5'h00;
    logic [31:0] queue_reset = 32'h0;
    cffc_offer_t tx_offer;
    logic [2:0] operating_mode;
    logic stall = 1'b0;
    logic [31:0] rd;
    logic er;
    int fails = 0;
    int checks = 0;
    int cycles = 0;

    cffc_top i_dut (.core_clk, .reset, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .rx_valid, .rx_frame,
        .rx_ready, .route_valid, .route_data, .route_ready, .tx_event,
        .remote_valid, .remote_index, .queue_reset, .tx_offer,
        .operating_mode);

    cffc_far_end i_far (.core_clk, .reset, .stall, .route_valid,
        .route_data, .route_ready);

    always #5 core_clk = ~core_clk;

    task automatic close_out;
        if (fails == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out

    // A hung handshake would otherwise stall the run forever.
    always @(posedge core_clk)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            fails = fails + 1;
            close_out();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks = checks + 1;
        if (seen !== exp)
        begin
            fails = fails + 1;
            $display("wrong value at %0t: saw %h, expected %h", $time,
                seen, exp);
        end
    endtask : check

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        // Ready, read data and error are taken at the edge that ends it.
        do
            @(posedge core_clk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rdc

    task automatic send(input logic [28:0] id);
        @(posedge core_clk);
        rx_valid <= 1'b1;
        rx_frame <= id;
        do
            @(posedge core_clk);
        while (rx_ready !== 1'b1);
        rx_valid <= 1'b0;
    endtask : send

    task automatic rt(input int k, input logic [28:0] id,
                      input logic [4:0] dest, input logic [4:0] filt);
        check({3'h0, i_far.got[k].id}, {3'h0, id});
        check({22'h0, i_far.got[k].dest, i_far.got[k].filter},
            {22'h0, dest, filt});
    endtask : rt

    // Kind bits: completed, aborted, arbitration lost, bus error, empty.
    task automatic ev(input logic [4:0] q, input logic [4:0] kind);
        @(posedge core_clk);
        tx_event <= {1'b1, q, kind};
        @(posedge core_clk);
        tx_event <= '0;
    endtask : ev

    task automatic rem(input logic [4:0] q);
        @(posedge core_clk);
        remote_valid <= 1'b1;
        remote_index <= q;
        @(posedge core_clk);
        remote_valid <= 1'b0;
    endtask : rem

    initial
    begin
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        rdc(12'h008, 32'h0);
        rdc(12'h018, 32'h0);
        rdc(12'h020, 32'h0080_0000);
        rdc(12'h030, 32'h0);
        check({31'h0, er}, 32'h1);
        rdc(12'h002, 32'h0);
        check({31'h0, er}, 32'h1);
        wr(12'h008, 32'hFF00_0045);
        rdc(12'h008, 32'hFF00_0045);
        wr(12'h008, 32'h8100_002A);
        rdc(12'h008, 32'hFF00_002A);
        wr(12'h008, 32'h0000_002A);
        rdc(12'h008, 32'h7F00_002A);
        wr(12'h044, 32'h1FFF_FFFF);
        wr(12'h04C, 32'h0);
        wr(12'h120, 32'h0000_0123);
        wr(12'h008, 32'h7F00_00AA);
        send(29'h123);
        send(29'h124);
        repeat (4) @(negedge core_clk);
        check(i_far.got.size(), 32'd1);
        rt(0, 29'h123, 5'd10, 5'd8);
        wr(12'h008, 32'hFF00_00AA);
        send(29'h124);
        send(29'h123);
        repeat (4) @(negedge core_clk);
        rt(1, 29'h124, 5'd31, 5'd11);
        rt(2, 29'h123, 5'd10, 5'd8);
        // Receiver stalls while three frames arrive; none may be lost.
        @(posedge core_clk);
        stall <= 1'b1;
        send(29'h200);
        send(29'h201);
        fork
            send(29'h202);
            begin
                repeat (4) @(negedge core_clk);
                check({31'h0, rx_ready}, 32'h0);
                @(posedge core_clk);
                stall <= 1'b0;
            end
        join
        repeat (4) @(negedge core_clk);
        for (int k = 0; k < 3; k++)
            rt(3 + k, 29'h200 + 29'(k), 5'd31, 5'd11);
        // A send request counts only once the queue already transmits.
        wr(12'h080, 32'h80);
        wr(12'h084, 32'h80);
        wr(12'h080, 32'h89);
        wr(12'h084, 32'h8B);
        wr(12'h088, 32'h0B);
        wr(12'h08C, 32'h84);
        wr(12'h090, 32'h80);
        repeat (3) @(negedge core_clk);
        check({24'h0, tx_offer}, 32'h87);
        rdc(12'h088, 32'h03);
        wr(12'h020, 32'h0);
        @(negedge core_clk);
        check({29'h0, operating_mode}, 32'h0);
        wr(12'h088, 32'h8B);
        rdc(12'h088, 32'h03);
        ev(5'd1, 5'b01000);
        rdc(12'h084, 32'hCB);
        ev(5'd1, 5'b00100);
        rdc(12'h084, 32'hEB);
        rdc(12'h084, 32'hCB);
        ev(5'd1, 5'b00010);
        rdc(12'h084, 32'hDB);
        rdc(12'h084, 32'hCB);
        ev(5'd1, 5'b10001);
        rdc(12'h084, 32'h83);
        rem(5'd3);
        rem(5'd4);
        rdc(12'h08C, 32'h8C);
        rdc(12'h090, 32'h80);
        repeat (3) @(negedge core_clk);
        check({24'h0, tx_offer}, 32'h81);
        ev(5'd4, 5'b00100);
        @(posedge core_clk);
        queue_reset <= 32'h10;
        @(posedge core_clk);
        queue_reset <= 32'h0;
        rdc(12'h090, 32'h80);
        // Queue zero carries the design's own assertions through each flag.
        ev(5'd0, 5'b00110);
        rdc(12'h080, 32'hB9);
        rdc(12'h080, 32'h89);
        ev(5'd0, 5'b01001);
        rdc(12'h080, 32'hC9);
        ev(5'd0, 5'b10001);
        rdc(12'h080, 32'h81);
        wr(12'h080, 32'h05);
        rem(5'd0);
        rdc(12'h080, 32'h8D);
        close_out();
    end
endmodule : tb
